// ===== das_config_strap_latch_bench.sv
// Self-checking bench for the strap latch block with a host model.
// Assumes the bus answers within a few cycles and a 100 MHz core clock.
`timescale 1ns/100ps
`include "dascfg_consts.vh"

module das_config_strap_latch_bench;
    logic core_clk = 1'h0, nrst = 1'h0;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, q;
    logic [3:0] s_wstrb = 4'hF, reg_rd_nibble = 4'h0;
    logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_bready = 1'h0, s_arvalid = 1'h0, s_rready = 1'h0;
    logic conv_out_active = 1'h0, reg_rd_active = 1'h0, reg_wr_strobe = 1'h0;
    logic [13:0] conv_result = 14'h0;
    logic [1:0] r;
    wire s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
    wire [1:0] s_bresp, s_rresp, input_range_r;
    wire [31:0] s_rdata;
    wire reset_pin_n, reference_source_select, sequencer_enable_strap, interface_type_select;
    wire hw_range_code_bit1, hw_range_code_bit0, shutdown, partial_reset, full_reset;
    wire [3:0] data_bus_in, data_bus_out, data_bus_oe, reg_wr_nibble_r;
    wire int_ref_enable_r, ext_ref_expected_r, seq_enable_r, seq_restricted_r, serial_if_r;
    wire sw_mode_r;
    wire [7:0] cfg = {int_ref_enable_r, ext_ref_expected_r, seq_enable_r, seq_restricted_r,
        serial_if_r, sw_mode_r, input_range_r};
    integer n_errors = 0, checks_done = 0, n_part = 0, n_full = 0, i;

    dascfg_top dut (.*);
    dascfg_host_model u_host (.*);

    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        n_part <= n_part + partial_reset;
        n_full <= n_full + full_reset;
    end

    task complete_run;
        begin
            if (n_errors == 0 && checks_done > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                n_errors = n_errors + 1;
                $display("unexpected %s: expected %h, seen %h", nm, e, g);
            end
        end
    endtask

    task tick(input integer n);
        repeat (n) @(posedge core_clk);
    endtask

    // One bus transfer; write when wr is high, result in q and r
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        integer k;
        begin
            @(posedge core_clk);
            s_awaddr <= a;
            s_araddr <= a;
            s_wdata <= d;
            s_awvalid <= wr;
            s_wvalid <= wr;
            s_bready <= wr;
            s_arvalid <= !wr;
            s_rready <= !wr;
            for (k = 0; k < 40; k++) begin
                @(posedge core_clk);
                if (s_awready) s_awvalid <= 1'h0;
                if (s_wready) s_wvalid <= 1'h0;
                if (s_arready) s_arvalid <= 1'h0;
                if ((s_bvalid && s_bready) || (s_rvalid && s_rready)) begin
                    q = s_rdata;
                    r = wr ? s_bresp : s_rresp;
                    s_bready <= 1'h0;
                    s_rready <= 1'h0;
                    k = 99;
                end
            end
            if (k < 100) begin
                chk("bus answer", 32'h1, 32'h0);
                complete_run;
            end
        end
    endtask

    initial begin
        tick(6);
        nrst <= 1'h1;
        tick(4);
        chk("config", 8'hB1, cfg);
        for (i = 2; i < 5; i++) begin
            u_host.set_straps(1'h1, 1'h1, i[1:0], 1'h0);
            tick(2);
            chk("range", (i == 4) ? 3 : i, input_range_r);
        end
        conv_result <= 14'h2AAE;
        conv_out_active <= 1'h1;
        tick(2);
        chk("bus", 8'hF8, {data_bus_oe, data_bus_out});
        conv_out_active <= 1'h0;
        reg_rd_active <= 1'h1;
        reg_rd_nibble <= 4'h5;
        tick(2);
        chk("bus enable", 4'h0, data_bus_oe);
        reg_rd_active <= 1'h0;
        u_host.set_straps(1'h0, 1'h0, 2'h0, 1'h1);
        tick(5);
        chk("config", 8'hB3, cfg);
        u_host.pulse(4);
        tick(4);
        u_host.pulse(5);
        tick(4);
        u_host.pulse(119);
        tick(4);
        chk("pulses", 16'h0002, {n_full[7:0], n_part[7:0]});
        fork
            u_host.pulse(125);
            begin
                tick(124);
                chk("shutdown", 2'h2, {shutdown, int_ref_enable_r});
            end
        join
        tick(6);
        chk("pulses", 16'h0102, {n_full[7:0], n_part[7:0]});
        chk("config", 8'h4F, cfg);
        conv_out_active <= 1'h1;
        tick(2);
        chk("bus enable", 4'h0, data_bus_oe);
        conv_out_active <= 1'h0;
        bus(1'h1, `DASCFG_ADDR_SW_CFG, 32'h6);
        chk("write resp", `DASCFG_RESP_OKAY, r);
        tick(1);
        chk("range", 2'h2, input_range_r);
        chk("seq enable", 1'h1, seq_enable_r);
        bus(1'h0, `DASCFG_ADDR_STATUS, 32'h0);
        chk("status", 32'hAC, q);
        bus(1'h0, `DASCFG_ADDR_EVENTS, 32'h0);
        chk("events", 32'h0102, q);
        bus(1'h0, 8'h10, 32'h0);
        chk("unmapped", `DASCFG_RESP_SLVERR, r);
        u_host.set_straps(1'h1, 1'h0, 2'h0, 1'h0);
        u_host.pulse(120);
        tick(6);
        chk("config", 8'h87, cfg);
        u_host.drive(1'h1, 4'hA);
        reg_wr_strobe <= 1'h1;
        tick(1);
        reg_wr_strobe <= 1'h0;
        u_host.drive(1'h0, 4'h0);
        tick(1);
        chk("write nibble", 4'hA, reg_wr_nibble_r);
        bus(1'h0, `DASCFG_ADDR_NIBBLE, 32'h0);
        chk("nibble reg", 32'hA, q);
        reg_rd_active <= 1'h1;
        tick(2);
        chk("bus", 8'hF5, {data_bus_oe, data_bus_out});
        u_host.set_straps(1'h0, 1'h0, 2'h2, 1'h0);
        u_host.pulse(120);
        tick(6);
        chk("config", 8'h42, cfg);
        chk("bus enable", 4'h0, data_bus_oe);
        complete_run;
    end
endmodule

// ===== dascfg_consts.vh
// Constants for the configuration strap latch block.
// Assumes a 100 MHz core clock and an AXI4-Lite bus with 8-bit addresses.
`ifndef DASCFG_CONSTS_VH
`define DASCFG_CONSTS_VH

// Timing, in ns and in cycles
`define DASCFG_CLK_PERIOD_NS 10
`define DASCFG_PARTIAL_MIN_NS 50
`define DASCFG_FULL_MIN_NS 1200
`define DASCFG_PARTIAL_CYC ((`DASCFG_PARTIAL_MIN_NS + `DASCFG_CLK_PERIOD_NS - 1) / `DASCFG_CLK_PERIOD_NS)
`define DASCFG_FULL_CYC ((`DASCFG_FULL_MIN_NS + `DASCFG_CLK_PERIOD_NS - 1) / `DASCFG_CLK_PERIOD_NS)

// Register byte addresses
`define DASCFG_ADDR_STATUS 8'h00
`define DASCFG_ADDR_SW_CFG 8'h04
`define DASCFG_ADDR_NIBBLE 8'h08
`define DASCFG_ADDR_EVENTS 8'h0C

// Status fields
`define DASCFG_ST_REF 0
`define DASCFG_ST_SEQ_STRAP 1
`define DASCFG_ST_SERIAL 2
`define DASCFG_ST_SW_MODE 3
`define DASCFG_ST_RANGE_LO 4
`define DASCFG_ST_SHUTDOWN 6
`define DASCFG_ST_SEQ_EN 7

// Software configuration fields and reset value
`define DASCFG_CFG_RANGE_LO 0
`define DASCFG_CFG_SEQ 2
`define DASCFG_CFG_RST 3'h3

// Range codes on the two mode pins
`define DASCFG_CODE_SW 2'h0
`define DASCFG_CODE_2V5 2'h1
`define DASCFG_CODE_5V 2'h2
`define DASCFG_CODE_10V 2'h3

// Bus responses
`define DASCFG_RESP_OKAY 2'h0
`define DASCFG_RESP_SLVERR 2'h2

`endif

// ===== dascfg_host_model.sv
// Board straps and host side of the configuration pins.
// Assumes the bench calls its tasks; lines nobody drives are pulled down.
`timescale 1ns/100ps

module dascfg_host_model (
    input wire core_clk,
    input wire [3:0] data_bus_out,
    input wire [3:0] data_bus_oe,
    output reg reset_pin_n = 1'h1,
    output reg reference_source_select = 1'h1,
    output reg sequencer_enable_strap = 1'h1,
    output reg hw_range_code_bit1 = 1'h0,
    output reg hw_range_code_bit0 = 1'h1,
    output reg interface_type_select = 1'h0,
    output wire [3:0] data_bus_in
);
    reg host_oe = 1'h0;
    reg [3:0] host_val = 4'h0;
    assign data_bus_in = (data_bus_oe & data_bus_out) | (~data_bus_oe & (host_oe ? host_val : 4'h0));

    task set_straps(input logic r, input logic s, input logic [1:0] c, input logic p);
        begin
            @(posedge core_clk);
            reference_source_select <= r;
            sequencer_enable_strap <= (c == 2'h0) ? 1'h0 : s;
            {hw_range_code_bit1, hw_range_code_bit0} <= c;
            interface_type_select <= p;
            host_oe <= p;
            host_val <= 4'h0;
        end
    endtask

    task drive(input logic en, input logic [3:0] v);
        begin
            @(posedge core_clk);
            host_oe <= en;
            host_val <= v;
        end
    endtask

    task pulse(input integer n);
        begin
            @(posedge core_clk);
            reset_pin_n <= 1'h0;
            repeat (n) @(posedge core_clk);
            reset_pin_n <= 1'h1;
        end
    endtask
endmodule

// ===== dascfg_rst_disc.v
// Reset pulse discriminator: measures low time of the reset pin.
// Assumes the reset pin is synchronous to core_clk.
`timescale 1ns/100ps
`include "dascfg_consts.vh"

module dascfg_rst_disc #(
    parameter CW = 16,
    parameter [CW-1:0] PARTIAL_CYC = `DASCFG_PARTIAL_CYC,
    parameter [CW-1:0] FULL_CYC = `DASCFG_FULL_CYC
) (
    input wire core_clk,
    input wire nrst,
    input wire reset_pin_n,
    output reg partial_pulse_r,
    output reg full_release_r,
    output reg shutdown_r
);

    localparam [CW-1:0] ONE = {{(CW-1){1'b0}}, 1'b1};
    localparam [CW-1:0] SAT = {CW{1'b1}};

    reg [CW-1:0] low_cnt_r;

    always @(posedge core_clk) begin
        if (!nrst) begin
            low_cnt_r <= {CW{1'b0}};
            partial_pulse_r <= 1'b0;
            full_release_r <= 1'b0;
            shutdown_r <= 1'b0;
        end else begin
            partial_pulse_r <= 1'b0;
            full_release_r <= 1'b0;
            if (!reset_pin_n) begin
                if (low_cnt_r != SAT) begin
                    low_cnt_r <= low_cnt_r + ONE;
                end
                // Held low past full length: shutdown
                shutdown_r <= (low_cnt_r >= FULL_CYC - ONE);
            end else begin
                low_cnt_r <= {CW{1'b0}};
                shutdown_r <= 1'b0;
                // Classify on the rising edge; short glitches ignored
                if (low_cnt_r >= FULL_CYC) begin
                    full_release_r <= 1'b1;
                end else if (low_cnt_r >= PARTIAL_CYC) begin
                    partial_pulse_r <= 1'b1;
                end
            end
        end
    end

endmodule

// ===== dascfg_top.v
// Configuration pin logic: strap latch, mode decode, reset, data bus low bits.
// Assumes all pins synchronous to core_clk; AXI4-Lite master on the bus side.
//
// What this block does
// - Reference select high enables internal reference; low expects external one.
// - Reference, sequencer and interface straps captured after core reset and at full reset release.
// - Reset pin low time decides between full and partial reset.
// - Reset pin held low keeps the device in shutdown.
// - Hardware mode: sequencer strap low disables, high enables restricted sequencer.
// - Range code 00 selects software mode, configured from internal registers.
// - Hardware mode codes: 01 is 2.5 V, 10 is 5 V, 11 is 10 V.
// - Mode latched at full reset; hardware range tracked continuously.
// - Interface select low chooses parallel, high chooses serial.
// - Parallel mode: result LSB on bit 2, bits 0 and 1 zero.
// - Software parallel mode: bits 0..3 carry register transfer low nibble.
// - Parallel data bits are three-state, driven only while outputting.
//
// Design decisions made here: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
`include "dascfg_consts.vh"

module dascfg_top #(
    parameter AW = 8,
    parameter CW = 16
) (
    input wire core_clk,
    input wire nrst,
    // AXI4-Lite slave
    input wire [AW-1:0] s_awaddr,
    input wire s_awvalid,
    output reg s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output reg s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    input wire [AW-1:0] s_araddr,
    input wire s_arvalid,
    output reg s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    // Configuration pins
    input wire reset_pin_n,
    input wire reference_source_select,
    input wire sequencer_enable_strap,
    input wire hw_range_code_bit1,
    input wire hw_range_code_bit0,
    input wire interface_type_select,
    // Parallel interface side
    input wire conv_out_active,
    input wire [13:0] conv_result,
    input wire reg_rd_active,
    input wire [3:0] reg_rd_nibble,
    input wire reg_wr_strobe,
    // Data bus bits 0..3 as three signals each
    input wire [3:0] data_bus_in,
    output reg [3:0] data_bus_out,
    output reg [3:0] data_bus_oe,
    // Decoded configuration
    output reg int_ref_enable_r,
    output reg ext_ref_expected_r,
    output reg seq_enable_r,
    output reg seq_restricted_r,
    output reg serial_if_r,
    output reg sw_mode_r,
    output reg [1:0] input_range_r,
    output reg [3:0] reg_wr_nibble_r,
    output wire shutdown,
    output wire partial_reset,
    output wire full_reset
);

    wire [1:0] hw_range_code;
    wire wr_fire;
    wire [31:0] status_w;
    wire [31:0] sw_cfg_w;
    wire [31:0] events_w;
    wire parallel_w;
    wire sw_par_w;

    reg cap_pending_r;
    reg ref_lat_r;
    reg seq_lat_r;
    reg ser_lat_r;
    reg sw_lat_r;
    reg [1:0] sw_range_r;
    reg sw_seq_r;
    reg [7:0] partial_cnt_r;
    reg [7:0] full_cnt_r;
    reg aw_hold_r;
    reg w_hold_r;
    reg [AW-1:0] awaddr_r;
    reg [31:0] wdata_r;
    reg [3:0] wstrb_r;

    assign hw_range_code = {hw_range_code_bit1, hw_range_code_bit0};

    // Address decode shared by read and write paths
    function dascfg_mapped;
        input [AW-1:0] addr;
        begin
            case (addr[7:0])
                `DASCFG_ADDR_STATUS: dascfg_mapped = 1'b1;
                `DASCFG_ADDR_SW_CFG: dascfg_mapped = 1'b1;
                `DASCFG_ADDR_NIBBLE: dascfg_mapped = 1'b1;
                `DASCFG_ADDR_EVENTS: dascfg_mapped = 1'b1;
                default: dascfg_mapped = 1'b0;
            endcase
        end
    endfunction

    // Completed write to one register with the given byte lane on
    function dascfg_wr_hit;
        input [AW-1:0] addr;
        input [7:0] target;
        input lane;
        begin
            dascfg_wr_hit = (addr[7:0] == target) && lane;
        end
    endfunction

    // Pulse length sorting and shutdown
    dascfg_rst_disc #(
        .CW(CW)
    ) u_disc (
        .core_clk(core_clk),
        .nrst(nrst),
        .reset_pin_n(reset_pin_n),
        .partial_pulse_r(partial_reset),
        .full_release_r(full_reset),
        .shutdown_r(shutdown)
    );

    // Strap capture on first edge after core reset or full reset release
    always @(posedge core_clk) begin
        if (!nrst) begin
            cap_pending_r <= 1'b1;
            ref_lat_r <= 1'b0;
            seq_lat_r <= 1'b0;
            ser_lat_r <= 1'b0;
            // Before the first capture, assume software mode
            sw_lat_r <= 1'b1;
        end else begin
            cap_pending_r <= 1'b0;
            if (cap_pending_r || full_reset) begin
                ref_lat_r <= reference_source_select;
                seq_lat_r <= sequencer_enable_strap;
                ser_lat_r <= interface_type_select;
                sw_lat_r <= (hw_range_code == `DASCFG_CODE_SW);
            end
        end
    end

    assign parallel_w = ~ser_lat_r;
    assign sw_par_w = parallel_w & sw_lat_r & ~shutdown;

    // Decoded configuration outputs
    always @(posedge core_clk) begin
        if (!nrst) begin
            int_ref_enable_r <= 1'b0;
            ext_ref_expected_r <= 1'b0;
            seq_enable_r <= 1'b0;
            seq_restricted_r <= 1'b0;
            serial_if_r <= 1'b0;
            sw_mode_r <= 1'b1;
            input_range_r <= `DASCFG_CODE_10V;
        end else begin
            // Shutdown forces the internal reference off
            int_ref_enable_r <= ref_lat_r & ~shutdown;
            ext_ref_expected_r <= ~ref_lat_r;
            serial_if_r <= ser_lat_r;
            sw_mode_r <= sw_lat_r;
            if (sw_lat_r) begin
                // Strap is grounded here; register bit decides
                seq_enable_r <= sw_seq_r;
                seq_restricted_r <= 1'b0;
                input_range_r <= sw_range_r;
            end else begin
                seq_enable_r <= seq_lat_r;
                seq_restricted_r <= seq_lat_r;
                // Live tracking; code 00 after latch keeps last range
                if (hw_range_code != `DASCFG_CODE_SW) begin
                    input_range_r <= hw_range_code;
                end
            end
        end
    end

    // Data bus bits 0..3
    always @(posedge core_clk) begin
        if (!nrst) begin
            data_bus_out <= 4'h0;
            data_bus_oe <= 4'h0;
        end else begin
            data_bus_out <= 4'h0;
            data_bus_oe <= 4'h0;
            // Serial mode: pins are grounded by the host, never driven
            if (parallel_w && !shutdown) begin
                // Read nibble takes priority over a conversion word
                if (sw_lat_r && reg_rd_active) begin
                    data_bus_out <= reg_rd_nibble;
                    data_bus_oe <= 4'hF;
                end else if (conv_out_active) begin
                    data_bus_out <= {conv_result[1:0], 2'b00};
                    data_bus_oe <= 4'hF;
                end
            end
        end
    end

    // Register write nibble, sampled only in software parallel mode
    always @(posedge core_clk) begin
        if (!nrst) begin
            reg_wr_nibble_r <= 4'h0;
        end else if (sw_par_w && reg_wr_strobe) begin
            reg_wr_nibble_r <= data_bus_in;
        end
    end

    // AXI4-Lite write channels
    assign wr_fire = aw_hold_r & w_hold_r & ~s_bvalid;

    always @(posedge core_clk) begin
        if (!nrst) begin
            s_awready <= 1'b1;
            s_wready <= 1'b1;
            s_bvalid <= 1'b0;
            s_bresp <= `DASCFG_RESP_OKAY;
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            awaddr_r <= {AW{1'b0}};
            wdata_r <= 32'h00000000;
            wstrb_r <= 4'h0;
        end else begin
            if (s_awvalid && s_awready) begin
                awaddr_r <= s_awaddr;
                aw_hold_r <= 1'b1;
                s_awready <= 1'b0;
            end
            if (s_wvalid && s_wready) begin
                wdata_r <= s_wdata;
                wstrb_r <= s_wstrb;
                w_hold_r <= 1'b1;
                s_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
                s_bvalid <= 1'b1;
                if (dascfg_mapped(awaddr_r)) begin
                    s_bresp <= `DASCFG_RESP_OKAY;
                end else begin
                    s_bresp <= `DASCFG_RESP_SLVERR;
                end
            end
            // Readies return only once the response is taken: one write at a time
            if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                s_awready <= 1'b1;
                s_wready <= 1'b1;
            end
        end
    end

    // Software configuration register, reloaded by full reset
    always @(posedge core_clk) begin
        if (!nrst) begin
            {sw_seq_r, sw_range_r} <= `DASCFG_CFG_RST;
        end else if (full_reset) begin
            // Full reset reloads the range and clears the sequencer bit
            {sw_seq_r, sw_range_r} <= `DASCFG_CFG_RST;
        end else if (wr_fire && dascfg_wr_hit(awaddr_r, `DASCFG_ADDR_SW_CFG, wstrb_r[0])) begin
            // Code 00 is not a range; keep the old one
            if (wdata_r[`DASCFG_CFG_RANGE_LO+1:`DASCFG_CFG_RANGE_LO] != 2'h0) begin
                sw_range_r <= wdata_r[`DASCFG_CFG_RANGE_LO+1:`DASCFG_CFG_RANGE_LO];
            end
            sw_seq_r <= wdata_r[`DASCFG_CFG_SEQ];
        end
    end

    // Reset event counters; a new event beats a clearing write
    always @(posedge core_clk) begin
        if (!nrst) begin
            partial_cnt_r <= 8'h00;
            full_cnt_r <= 8'h00;
        end else begin
            if (wr_fire && dascfg_wr_hit(awaddr_r, `DASCFG_ADDR_EVENTS, wstrb_r[0])) begin
                partial_cnt_r <= 8'h00;
            end
            if (wr_fire && dascfg_wr_hit(awaddr_r, `DASCFG_ADDR_EVENTS, wstrb_r[1])) begin
                full_cnt_r <= 8'h00;
            end
            if (partial_reset && partial_cnt_r != 8'hFF) begin
                partial_cnt_r <= partial_cnt_r + 8'h01;
            end
            if (full_reset && full_cnt_r != 8'hFF) begin
                full_cnt_r <= full_cnt_r + 8'h01;
            end
        end
    end

    // Read data sources
    assign status_w = {24'h000000, seq_enable_r, shutdown, input_range_r,
                       sw_lat_r, ser_lat_r, seq_lat_r, ref_lat_r};
    assign sw_cfg_w = {29'h00000000, sw_seq_r, sw_range_r};
    assign events_w = {16'h0000, full_cnt_r, partial_cnt_r};

    // AXI4-Lite read channels
    always @(posedge core_clk) begin
        if (!nrst) begin
            s_arready <= 1'b1;
            s_rvalid <= 1'b0;
            s_rdata <= 32'h00000000;
            s_rresp <= `DASCFG_RESP_OKAY;
        end else begin
            if (s_arvalid && s_arready) begin
                s_arready <= 1'b0;
                s_rvalid <= 1'b1;
                s_rresp <= `DASCFG_RESP_OKAY;
                case (s_araddr[7:0])
                    `DASCFG_ADDR_STATUS: s_rdata <= status_w;
                    `DASCFG_ADDR_SW_CFG: s_rdata <= sw_cfg_w;
                    `DASCFG_ADDR_NIBBLE: s_rdata <= {28'h0000000, reg_wr_nibble_r};
                    `DASCFG_ADDR_EVENTS: s_rdata <= events_w;
                    default: s_rdata <= 32'h00000000;
                endcase
                if (!dascfg_mapped(s_araddr)) begin
                    s_rresp <= `DASCFG_RESP_SLVERR;
                end
            end
            // Address channel reopens once the answer is taken
            if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
                s_arready <= 1'b1;
            end
        end
    end

endmodule

// ===== dascfg_top_asserts.sv
// Concurrent checks on the strap latch block, bound to its top module.
// Assumes all pins are synchronous to core_clk and sampled on its rising edge.
`timescale 1ns/100ps
`include "dascfg_consts.vh"

module dascfg_top_asserts (
    input logic core_clk,
    input logic nrst,
    input logic reset_pin_n,
    input logic hw_range_code_bit1,
    input logic hw_range_code_bit0,
    input logic conv_out_active,
    input logic [13:0] conv_result,
    input logic reg_wr_strobe,
    input logic [3:0] data_bus_in,
    input logic [3:0] data_bus_out,
    input logic [3:0] data_bus_oe,
    input logic int_ref_enable_r,
    input logic ext_ref_expected_r,
    input logic seq_enable_r,
    input logic seq_restricted_r,
    input logic serial_if_r,
    input logic sw_mode_r,
    input logic [1:0] input_range_r,
    input logic [3:0] reg_wr_nibble_r,
    input logic shutdown,
    input logic full_reset
);
    reg [7:0] low_cnt_r;
    reg [3:0] fr_hist_r;
    wire [1:0] conv_lo = conv_result[1:0];
    wire [1:0] code = {hw_range_code_bit1, hw_range_code_bit0};
    wire [2:0] held = {ext_ref_expected_r, serial_if_r, sw_mode_r};
    // Settled: no full reset in the last few cycles
    wire quiet = fr_hist_r == 4'h0 && !full_reset;

    always @(posedge core_clk) begin
        if (!nrst) begin
            low_cnt_r <= 8'h00;
            fr_hist_r <= 4'hF;
        end else begin
            low_cnt_r <= reset_pin_n ? 8'h00 : low_cnt_r + {7'h00, low_cnt_r != 8'hFF};
            fr_hist_r <= {fr_hist_r[2:0], full_reset};
        end
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!nrst);

    sequence s_long_release;
        shutdown && reset_pin_n;
    endsequence

    a_full_after_low: assert property (s_long_release |-> ##[1:2] full_reset)
        else $error("full reset pulse missing");
    a_full_one_pulse: assert property (full_reset |=> !full_reset)
        else $error("full reset pulse too long");
    a_shutdown_count: assert property (shutdown == (low_cnt_r >= `DASCFG_FULL_CYC))
        else $error("shutdown level wrong");
    a_ref_gated: assert property (shutdown |=> !int_ref_enable_r)
        else $error("reference on in shutdown");
    a_straps_held: assert property ($changed(held) |-> fr_hist_r != 4'h0)
        else $error("strap outputs moved");
    a_range_tracks: assert property (!sw_mode_r && quiet && code != 2'h0
        |=> input_range_r == $past(code))
        else $error("range not tracked");
    a_seq_hw_only: assert property (seq_restricted_r && quiet |-> seq_enable_r && !sw_mode_r)
        else $error("restricted sequencer wrong");
    a_serial_quiet: assert property (serial_if_r && quiet |-> data_bus_oe == 4'h0)
        else $error("bus driven in serial mode");
    a_conv_lsb_pos: assert property (!serial_if_r && !sw_mode_r && !shutdown && quiet
        && conv_out_active |=> data_bus_oe == 4'hF && data_bus_out == {$past(conv_lo), 2'h0})
        else $error("conversion bits wrong");
    a_wr_nibble: assert property (sw_mode_r && !serial_if_r && !shutdown
        && quiet && reg_wr_strobe |=> reg_wr_nibble_r == $past(data_bus_in))
        else $error("write nibble wrong");
endmodule

bind dascfg_top dascfg_top_asserts u_chk (.*);
